/* File: hw/vfr_delay_timer.sv */
// Delay timer: counts 2**code time units of unit_len base ticks each
`default_nettype none
module vfr_delay_timer
	import vfr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic [15:0] unit_len,
	input wire logic [2:0] code,
	// Result
	output logic done
);
	localparam logic [7:0] TICK_LAST = 8'(VFR_TICK_CYC - 1);

	logic [7:0] div_q; // Base tick divider
	logic [15:0] unit_q; // Ticks within the current unit
	logic [7:0] mult_q; // Units elapsed
	logic busy_q; // Timer armed
	logic done_q; // One-cycle completion pulse
	wire tick = busy_q && (div_q == TICK_LAST);
	// A zero unit length would wrap to 65536 ticks, so it is read as one tick
	wire [15:0] unit_last = (unit_len == 16'h0000) ? 16'h0000 :
		unit_len - 16'h0001;
	wire unit_end = tick && (unit_q == unit_last);
	wire [7:0] mult_last = (8'h01 << code) - 8'h01;
	wire all_end = unit_end && (mult_q == mult_last);

	// A restart drops any count in flight so intervals never overlap
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= 8'h00;
			unit_q <= 16'h0000;
			mult_q <= 8'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (start)
		begin
			div_q <= 8'h00;
			unit_q <= 16'h0000;
			mult_q <= 8'h00;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end
		else
		begin
			div_q <= (!busy_q || tick) ? 8'h00 : div_q + 8'h01;
			unit_q <= unit_end ? 16'h0000 : (tick ? unit_q + 16'h0001 : unit_q);
			mult_q <= unit_end ? mult_q + 8'h01 : mult_q;
			busy_q <= busy_q && !all_end;
			done_q <= all_end;
		end
	end

	assign done = done_q;
endmodule : vfr_delay_timer
`default_nettype wire

/* File: hw/vfr_pkg.sv */
// Package: constants and types for the output-voltage fault retry sequencer
`default_nettype none
package vfr_pkg;
	// Command codes of the threshold registers
	localparam logic [7:0] VFR_OVW_CODE = 8'h42;
	localparam logic [7:0] VFR_UVW_CODE = 8'h43;
	localparam logic [7:0] VFR_UVF_CODE = 8'h44;
	// Code of the time-unit register that feeds TIME_UNIT
	localparam logic [7:0] VFR_TIME_UNIT_CODE = 8'hD2;
	// Field positions inside the fault-response byte
	localparam int VFR_RESP_HI = 7;
	localparam int VFR_RESP_LO = 6;
	localparam int VFR_RETRY_HI = 5;
	localparam int VFR_RETRY_LO = 3;
	localparam int VFR_DELAY_HI = 2;
	localparam int VFR_DELAY_LO = 0;
	// Values after reset of the thresholds
	localparam logic [15:0] VFR_OVW_RESET = 16'hFFFF;
	localparam logic [15:0] VFR_UVW_RESET = 16'h0000;
	localparam logic [15:0] VFR_UVF_RESET = 16'h0000;
	// Retry codes
	localparam logic [2:0] VFR_RETRY_NONE = 3'h0;
	localparam logic [2:0] VFR_RETRY_FOREVER = 3'h7;
	// Base tick of the time unit: 1000 ns at a 4 ns clock
	localparam int VFR_CLK_NS = 4;
	localparam int VFR_TICK_NS = 1000;
	localparam int VFR_TICK_CYC = (VFR_TICK_NS + VFR_CLK_NS - 1) / VFR_CLK_NS;
	// Fault responses
	typedef enum logic [1:0]
	{
		VFR_IGNORE = 2'h0,
		VFR_RUN_THEN_RETRY = 2'h1,
		VFR_OFF_AND_RETRY = 2'h2,
		VFR_OFF_WHILE_FAULT = 2'h3
	} vfr_resp_t;
	// Sequencer states, Gray along run, delay, wait, attempt, latch
	typedef enum logic [2:0]
	{
		VFR_ST_RUN = 3'h0,
		VFR_ST_DELAY = 3'h1,
		VFR_ST_WAIT = 3'h3,
		VFR_ST_ATTEMPT = 3'h2,
		VFR_ST_LATCH = 3'h6,
		VFR_ST_HOLD = 3'h7
	} vfr_state_t;
endpackage : vfr_pkg
`default_nettype wire

/* File: hw/vfr_sequencer.sv */
// Output-voltage fault response and restart sequencer
// How it works
// - Retry codes 1..6 give that many attempts
// - All attempts fail: output off until cleared
// - Attempt starts spaced by delay times unit
// - Code 111 retries until off or shutdown
// - Delay code n means 2**n time units
// - Delay is run-on time or retry spacing
// - Time unit comes from register code 0xD2
// - Over-voltage warning threshold at code 0x42
// - Under-voltage warning threshold at code 0x43
// - Under-voltage fault threshold at code 0x44
// - Response field picks ignore/run/off/hold
// - Retry field bits 5:3; zero never restarts
`default_nettype none
module vfr_sequencer
	import vfr_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Command port for the threshold registers
	input wire logic [7:0] CMD_CODE,
	input wire logic WR_STB,
	input wire logic [15:0] WR_DATA,
	input wire logic RD_STB,
	output logic [15:0] RD_DATA,
	output logic RD_VALID,
	// Fault configuration
	input wire logic [7:0] FAULT_RESPONSE,
	input wire logic [15:0] TIME_UNIT,
	// Measurement and commands
	input wire logic [15:0] VOUT_MEAS,
	input wire logic OUTPUT_ON_CMD,
	input wire logic CLEAR_FAULTS,
	input wire logic OTHER_FAULT,
	// Power stage and status
	output logic POWER_STAGE_EN,
	output logic OV_WARN_STATUS,
	output logic UV_WARN_STATUS,
	output logic UV_FAULT_STATUS,
	output logic RETRY_ACTIVE
);
	logic [15:0] ovw_q; // Over-voltage warning threshold
	logic [15:0] uvw_q; // Under-voltage warning threshold
	logic [15:0] uvf_q; // Under-voltage fault threshold
	logic [15:0] rd_data_q; // Read data
	logic rd_valid_q; // Read answer strobe
	logic ovw_st_q; // Sticky warning flags
	logic uvw_st_q;
	logic uvf_st_q; // Sticky fault flag
	vfr_state_t state_q; // Sequencer state
	vfr_state_t state_d;
	logic [2:0] left_q; // Attempts still allowed
	logic [2:0] left_d;
	logic seen_q; // Fault seen during current attempt
	logic seen_d;
	logic tmr_start; // Timer restart request
	logic tmr_done; // Timer expiry pulse
	logic en_q; // Registered stage enable

	// Field decode of the response byte
	wire [1:0] resp = FAULT_RESPONSE[VFR_RESP_HI:VFR_RESP_LO];
	wire [2:0] retry = FAULT_RESPONSE[VFR_RETRY_HI:VFR_RETRY_LO];
	wire [2:0] dly = FAULT_RESPONSE[VFR_DELAY_HI:VFR_DELAY_LO];
	wire forever_on = (retry == VFR_RETRY_FOREVER);
	// Threshold comparisons on the unsigned output-voltage code
	wire ov_warn = VOUT_MEAS > ovw_q;
	wire uv_warn = VOUT_MEAS < uvw_q;
	wire uv_fault = VOUT_MEAS < uvf_q;
	// Write and read decode
	wire wr_ovw = WR_STB && (CMD_CODE == VFR_OVW_CODE);
	wire wr_uvw = WR_STB && (CMD_CODE == VFR_UVW_CODE);
	wire wr_uvf = WR_STB && (CMD_CODE == VFR_UVF_CODE);
	wire [15:0] rd_mux = (CMD_CODE == VFR_OVW_CODE) ? ovw_q :
		(CMD_CODE == VFR_UVW_CODE) ? uvw_q :
		(CMD_CODE == VFR_UVF_CODE) ? uvf_q : 16'h0000;
	// A fault acts only when the response is not ignore
	wire fault_act = uv_fault && (resp != VFR_IGNORE);

	// Delay generator; TIME_UNIT holds the 0xD2 unit as base ticks
	vfr_delay_timer u_timer
	(
		.clk(CLK),
		.rst_n(RST_N),
		.start(tmr_start),
		.unit_len(TIME_UNIT),
		.code(dly),
		.done(tmr_done)
	);

	// Threshold registers and read port
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ovw_q <= VFR_OVW_RESET;
			uvw_q <= VFR_UVW_RESET;
			uvf_q <= VFR_UVF_RESET;
			rd_data_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			if (wr_ovw)
				ovw_q <= WR_DATA;
			if (wr_uvw)
				uvw_q <= WR_DATA;
			if (wr_uvf)
				uvf_q <= WR_DATA;
			if (RD_STB)
				rd_data_q <= rd_mux;
			rd_valid_q <= RD_STB;
		end
	end

	// Sticky status; a new event in the clearing cycle wins
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ovw_st_q <= 1'b0;
			uvw_st_q <= 1'b0;
			uvf_st_q <= 1'b0;
		end
		else
		begin
			ovw_st_q <= ov_warn || (ovw_st_q && !CLEAR_FAULTS);
			uvw_st_q <= uv_warn || (uvw_st_q && !CLEAR_FAULTS);
			uvf_st_q <= (fault_act && OUTPUT_ON_CMD) ||
				(uvf_st_q && !CLEAR_FAULTS);
		end
	end

	// Next-state logic of the sequencer
	always_comb
	begin
		state_d = state_q;
		left_d = left_q;
		seen_d = seen_q;
		tmr_start = 1'b0;
		case (state_q)
			VFR_ST_RUN:
			begin
				// Fault while on picks the response path; a stage that is
				// still off reads low, so only an enabled stage is judged
				if (fault_act && OUTPUT_ON_CMD && en_q)
				begin
					tmr_start = 1'b1;
					left_d = retry;
					case (resp)
						VFR_RUN_THEN_RETRY: state_d = VFR_ST_DELAY;
						VFR_OFF_AND_RETRY: state_d = (retry == VFR_RETRY_NONE) ?
							VFR_ST_LATCH : VFR_ST_WAIT;
						default: state_d = VFR_ST_HOLD;
					endcase
				end
			end
			VFR_ST_DELAY:
			begin
				// Keep running for the delay; fault gone means no action
				if (!uv_fault)
					state_d = VFR_ST_RUN;
				else if (tmr_done)
				begin
					tmr_start = 1'b1;
					state_d = (retry == VFR_RETRY_NONE) ?
						VFR_ST_LATCH : VFR_ST_WAIT;
				end
			end
			VFR_ST_WAIT:
			begin
				// Output off for one interval before the first attempt
				if (tmr_done)
				begin
					tmr_start = 1'b1;
					seen_d = 1'b0;
					left_d = forever_on ? left_q : left_q - 3'h1;
					state_d = VFR_ST_ATTEMPT;
				end
			end
			VFR_ST_ATTEMPT:
			begin
				// Attempt lasts one interval; a fault turns the stage off for the rest of it
				if (uv_fault)
					seen_d = 1'b1;
				if (tmr_done)
				begin
					if (!seen_q && !uv_fault)
						state_d = VFR_ST_RUN;
					else if (forever_on || left_q != 3'h0)
					begin
						tmr_start = 1'b1;
						seen_d = 1'b0;
						left_d = forever_on ? left_q : left_q - 3'h1;
					end
					else
						state_d = VFR_ST_LATCH;
				end
			end
			VFR_ST_LATCH:
			begin
				// Stays off until a clear-faults command
				if (CLEAR_FAULTS)
					state_d = VFR_ST_RUN;
			end
			VFR_ST_HOLD:
			begin
				// Off while the fault persists; a stage that is off reads
				// low, so a clear-faults command is the usual way out
				if (!uv_fault || CLEAR_FAULTS)
					state_d = VFR_ST_RUN;
			end
			default: state_d = VFR_ST_RUN;
		endcase
		// Commanding off ends any sequence; on again starts clean
		if (!OUTPUT_ON_CMD)
			state_d = VFR_ST_RUN;
		else if (OTHER_FAULT)
			state_d = VFR_ST_LATCH;
	end

	// Sequencer registers
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_q <= VFR_ST_RUN;
			left_q <= 3'h0;
			seen_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			left_q <= left_d;
			seen_q <= seen_d;
		end
	end

	// Output stage: off in wait, latch, hold and a failing attempt
	wire en_d = OUTPUT_ON_CMD && ((state_d == VFR_ST_RUN) ||
		(state_d == VFR_ST_DELAY) ||
		((state_d == VFR_ST_ATTEMPT) && !seen_d));
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			en_q <= 1'b0;
		else
			en_q <= en_d;
	end

	assign POWER_STAGE_EN = en_q;
	assign RD_DATA = rd_data_q;
	assign RD_VALID = rd_valid_q;
	assign OV_WARN_STATUS = ovw_st_q;
	assign UV_WARN_STATUS = uvw_st_q;
	assign UV_FAULT_STATUS = uvf_st_q;
	assign RETRY_ACTIVE = (state_q == VFR_ST_WAIT) ||
		(state_q == VFR_ST_ATTEMPT);
endmodule : vfr_sequencer
`default_nettype wire

/* File: sim/vfr_sequencer_props.sv */
// Port assertions for the fault retry sequencer
`default_nettype none
module vfr_sequencer_props
	import vfr_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] CMD_CODE,
	input wire logic WR_STB,
	input wire logic [15:0] WR_DATA,
	input wire logic RD_STB,
	input wire logic [15:0] RD_DATA,
	input wire logic RD_VALID,
	// Control and status
	input wire logic [7:0] FAULT_RESPONSE,
	input wire logic OUTPUT_ON_CMD,
	input wire logic CLEAR_FAULTS,
	input wire logic OTHER_FAULT,
	input wire logic POWER_STAGE_EN,
	input wire logic OV_WARN_STATUS,
	input wire logic UV_FAULT_STATUS,
	input wire logic RETRY_ACTIVE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Write then read of the over-voltage warning threshold
	sequence s_wr_ovw;
		WR_STB && CMD_CODE == VFR_OVW_CODE;
	endsequence
	sequence s_rd_ovw;
		RD_STB && !WR_STB && CMD_CODE == VFR_OVW_CODE;
	endsequence
	chk_rd_valid_pulse: assert property (RD_STB |=> RD_VALID)
		else $error("read strobe not answered");
	chk_rd_valid_idle: assert property (!RD_STB |=> !RD_VALID)
		else $error("read valid without strobe");
	chk_write_read_back: assert property (s_wr_ovw ##1 !WR_STB ##1 s_rd_ovw
		|=> RD_DATA == $past(WR_DATA, 3)) else $error("threshold readback");
	chk_unmapped_zero: assert property (RD_STB && !(CMD_CODE inside
		{8'h42, 8'h43, 8'h44}) |=> RD_DATA == 16'h0000)
		else $error("unmapped read not zero");
	chk_rd_data_hold: assert property (!RD_STB |=> $stable(RD_DATA))
		else $error("read data moved");
	chk_off_stops: assert property (!OUTPUT_ON_CMD |=>
		!POWER_STAGE_EN && !RETRY_ACTIVE) else $error("off not obeyed");
	chk_other_fault_off: assert property (OTHER_FAULT |=> !POWER_STAGE_EN)
		else $error("other fault left stage on");
	chk_ignore_keeps_on: assert property (FAULT_RESPONSE[7:6] == 2'h0
		&& OUTPUT_ON_CMD && !OTHER_FAULT && POWER_STAGE_EN |=> POWER_STAGE_EN)
		else $error("ignore response dropped stage");
	chk_ov_warn_sticky: assert property (OV_WARN_STATUS && !CLEAR_FAULTS
		|=> OV_WARN_STATUS) else $error("warning flag lost");
	chk_fault_sticky: assert property (UV_FAULT_STATUS && !CLEAR_FAULTS
		|=> UV_FAULT_STATUS) else $error("fault flag lost");
	// Output commanded off for a cycle, then on again
	sequence s_off_on;
		!OUTPUT_ON_CMD ##1 (OUTPUT_ON_CMD && !OTHER_FAULT);
	endsequence
	chk_off_on_restart: assert property (s_off_on |=>
		POWER_STAGE_EN) else $error("off-on did not restart");
endmodule : vfr_sequencer_props
bind vfr_sequencer vfr_sequencer_props u_props (.CLK(CLK), .RST_N(RST_N),
	.CMD_CODE(CMD_CODE), .WR_STB(WR_STB), .WR_DATA(WR_DATA),
	.RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
	.FAULT_RESPONSE(FAULT_RESPONSE), .OUTPUT_ON_CMD(OUTPUT_ON_CMD),
	.CLEAR_FAULTS(CLEAR_FAULTS), .OTHER_FAULT(OTHER_FAULT),
	.POWER_STAGE_EN(POWER_STAGE_EN), .OV_WARN_STATUS(OV_WARN_STATUS),
	.UV_FAULT_STATUS(UV_FAULT_STATUS), .RETRY_ACTIVE(RETRY_ACTIVE));
`default_nettype wire

/* File: sim/vfr_sequencer_test.sv */
// Self-checking bench for the fault retry sequencer
`default_nettype none
module vfr_sequencer_test
	import vfr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, on = 1, clr = 0, oth = 0;
	logic shrt = 0, en, en_q = 0, rdv, ovw, uvw, uvf, ract;
	logic [7:0] cmd = 8'h00, resp = 8'h00;
	logic [15:0] wd = 16'h0000, tu = 16'h0001, vout, rdd;
	logic [15:0] regs [3] = '{16'hFFFF, 16'h0000, 16'h0000};
	logic [31:0] rnd = 32'h73326FFE;
	int n_errors = 0, n_tests = 0, cyc = 0, rises = 0, t1 = 0, t2 = 0, k;
	vfr_sequencer u_dut (.CLK(clk), .RST_N(rst_n), .CMD_CODE(cmd),
		.WR_STB(wr), .WR_DATA(wd), .RD_STB(rd), .RD_DATA(rdd),
		.RD_VALID(rdv), .FAULT_RESPONSE(resp), .TIME_UNIT(tu),
		.VOUT_MEAS(vout), .OUTPUT_ON_CMD(on), .CLEAR_FAULTS(clr),
		.OTHER_FAULT(oth), .POWER_STAGE_EN(en), .OV_WARN_STATUS(ovw),
		.UV_WARN_STATUS(uvw), .UV_FAULT_STATUS(uvf), .RETRY_ACTIVE(ract));
	vfr_stage_model u_stage (.en(en), .short_i(shrt), .vout(vout));
	// 4 ns clock
	initial
		forever #2 clk = ~clk;
	// Restart counter and hang guard
	always @(posedge clk)
	begin
		cyc++;
		// Compare with the previous edge before it is overwritten
		if (en && !en_q)
		begin
			rises++;
			t1 = (rises == 1) ? cyc : t1;
			t2 = (rises == 2) ? cyc : t2;
		end
		en_q = en;
		if (cyc == 40000)
		begin
			n_errors++;
			end_sim();
		end
	end
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic end_sim();
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// Bus cycles start and end on a clock edge
	task automatic wr16(logic [7:0] c, logic [15:0] d);
		cmd <= c;
		wd <= d;
		wr <= 1'b1;
		tick(1);
		wr <= 1'b0;
		tick(1);
	endtask : wr16
	task automatic rd16(logic [7:0] c, logic [15:0] e);
		cmd <= c;
		rd <= 1'b1;
		tick(1);
		rd <= 1'b0;
		#1;
		chk("rd_valid", 16'h1, 16'(rdv));
		chk("rd_data", e, rdd);
		tick(1);
	endtask : rd16
	// Host clear with the response parked at ignore during restart
	task automatic clear_all();
		resp <= 8'h00;
		shrt <= 1'b0;
		oth <= 1'b0;
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(4);
		#1;
		chk("cleared_en", 16'h1, 16'(en));
		tick(1);
	endtask : clear_all
	// One fault episode: response off-and-retry, retry n, delay d
	task automatic episode(logic [1:0] r, logic [2:0] n, logic [2:0] d);
		int t;
		t = VFR_TICK_CYC << d;
		resp <= {r, n, d};
		shrt <= 1'b1;
		rises = 0;
		tick((n + 3) * t);
		#1;
		if (n == 3'h7)
			chk("attempts", 16'h1, 16'(rises >= 7));
		else
			chk("attempts", 16'(n), 16'(rises));
		if (n > 3'h1)
			chk("spacing", 16'h1, 16'(t2 - t1 inside {[t:t + 2]}));
		chk("latched", 16'h0, 16'(en && n != 3'h7));
		chk("uv_fault", 16'h1, 16'(uvf));
		tick(1);
		on <= 1'b0;
		tick(2);
		#1;
		chk("off_retry", 16'h0, 16'(ract | en));
		tick(1);
		on <= 1'b1;
		clear_all();
	endtask : episode
	initial
	begin
		tick(4);
		rst_n <= 1'b1;
		for (k = 0; k < 3; k++)
			rd16(VFR_OVW_CODE + 8'(k), regs[k]);
		rd16(VFR_TIME_UNIT_CODE, 16'h0000);
		for (int i = 0; i < 16; i++)
		begin
			rnd = lfsr(rnd);
			k = int'(rnd[17:16]);
			wr16(VFR_OVW_CODE + 8'(k), rnd[15:0]);
			if (k < 3)
				regs[k] = rnd[15:0];
			rd16(VFR_OVW_CODE + 8'(k), (k < 3) ? regs[k] : 16'h0000);
		end
		wr16(VFR_OVW_CODE, 16'h3000);
		wr16(VFR_UVW_CODE, 16'h5000);
		wr16(VFR_UVF_CODE, 16'h1000);
		clear_all();
		#1;
		chk("ov_warn", 16'h1, 16'(ovw));
		chk("uv_warn", 16'h1, 16'(uvw));
		tick(1);
		wr16(VFR_OVW_CODE, 16'hFFFF);
		wr16(VFR_UVW_CODE, 16'h0000);
		clear_all();
		#1;
		chk("warn_clr", 16'h0, 16'(ovw | uvw));
		tick(1);
		shrt <= 1'b1;
		tick(300);
		#1;
		chk("ignore", 16'h1, 16'(en & ~uvf));
		tick(1);
		resp <= 8'hC0;
		tick(3);
		#1;
		chk("hold_off", 16'h0, 16'(en));
		tick(1);
		clear_all();
		resp <= 8'h50;
		shrt <= 1'b1;
		tick(VFR_TICK_CYC - 10);
		#1;
		chk("run_on", 16'h1, 16'(en));
		tick(20);
		#1;
		chk("run_off", 16'h0, 16'(en));
		chk("retry_act", 16'h1, 16'(ract));
		tick(1);
		// A pending retry is left by turning the output off and on
		on <= 1'b0;
		tick(1);
		on <= 1'b1;
		clear_all();
		for (k = 0; k < 8; k++)
			episode(2'h2, 3'(k), 3'(k % 3));
		oth <= 1'b1;
		tick(2);
		#1;
		chk("other_off", 16'h0, 16'(en));
		tick(1);
		clear_all();
		end_sim();
	end
endmodule : vfr_sequencer_test
`default_nettype wire

/* File: sim/vfr_stage_model.sv */
// Power stage model seen from the sequencer's measurement input
`default_nettype none
module vfr_stage_model
	import vfr_pkg::*;
(
	// Stage control
	input wire logic en,
	input wire logic short_i,
	// Measured output voltage
	output logic [15:0] vout
);
	timeunit 1ns;
	timeprecision 1ps;
	// A stage that is off reads zero, so a restart must cope with it
	assign vout = !en ? 16'h0000 : (short_i ? 16'h0800 : 16'h4000);
endmodule : vfr_stage_model
`default_nettype wire
